// ### verilog/hwd_halt_wake.sv
/*
 * Halt, wake-up and watchdog controller. Holds the watchdog control,
 * mode, port A wake mask, status and option registers; tracks idle and
 * stop states; decides how the core resumes.
 * Assumes the core gives one-cycle instruction strobes and samples
 * the resume pulses; inputs are synchronous to CLK; sub_tick is a
 * one-cycle pulse per low-rate clock period.
 */
`timescale 1ns/100ps
module hwd_halt_wake #(
  parameter int PORT_W       = 8,
  parameter int STARTUP_CNT  = hwd_pkg::HWD_STARTUP_CYCLES
) (
  input  wire logic                CLK,
  input  wire logic                RESET_N,
  input  wire logic [3:0]          ADDR,
  input  wire logic [7:0]          WDATA,
  input  wire logic                WR,
  input  wire logic                RD,
  output logic [7:0]               RDATA,
  input  wire hwd_pkg::hwd_cmd_t   CMD,
  input  wire logic                EXT_RESET,
  input  wire logic [PORT_W-1:0]   PORT_A,
  input  wire logic                IRQ_REQ,
  input  wire logic                IRQ_EN,
  input  wire logic                STACK_FULL,
  input  wire logic                SUB_TICK,
  input  wire logic                HIGH_OSC_SRC,
  output hwd_pkg::hwd_resume_t     RESUME,
  output hwd_pkg::hwd_mode_t       MODE,
  output logic                     CORE_CLK_EN,
  output logic                     SUB_CLK_EN,
  output logic                     RUN_ON_SUB,
  output logic                     HIGH_OSC_STABLE
);
  import hwd_pkg::*;

  // ****************************************
  // Registers
  // ****************************************
  logic [7:0]        ctrl_r;
  logic [7:0]        mode_reg_r;
  logic [PORT_W-1:0] wake_mask_r;
  logic [7:0]        cfg_r;
  logic              pdf_r;
  logic              expiry_r;
  hwd_mode_t         state_r;
  logic [PORT_W-1:0] port_a_r;
  logic              irq_pre_r;
  logic [1:0]        div_r;
  logic              last_clr_two_r;
  logic              low_osc_ok_r;
  hwd_osc_t          osc_r;
  logic [10:0]       sst_r;
  logic              dog_ovf;
  logic              dog_enabled;
  logic              dog_tick;
  logic              dog_clear;
  logic              sw_clear;
  logic              halt_go;
  logic              port_wake;
  logic              irq_wake;
  logic              idle_bit;
  logic              keep_bit;

  assign idle_bit = mode_reg_r[HWD_MODE_IDLE_BIT];
  assign keep_bit = ctrl_r[HWD_CTRL_KEEP_BIT];

  // Disable needs both the option and the key
  assign dog_enabled = cfg_r[HWD_CFG_DOG_EN_BIT] ||
                       (ctrl_r[HWD_CTRL_KEY_LSB +: 4] != HWD_KEY_DISABLE);

  // ****************************************
  // Register bus
  // ****************************************
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      ctrl_r      <= HWD_CTRL_RESET;
      mode_reg_r  <= HWD_MODE_RESET;
      wake_mask_r <= PORT_W'(HWD_WAKE_RESET);
      cfg_r       <= HWD_CONFIG_RESET;
    end else if (WR) begin
      unique case (ADDR)
        HWD_ADDR_DOG_CTRL:  ctrl_r      <= WDATA;
        HWD_ADDR_MODE:      mode_reg_r  <= WDATA;
        HWD_ADDR_WAKE_MASK: wake_mask_r <= WDATA[PORT_W-1:0];
        HWD_ADDR_CONFIG:    cfg_r       <= WDATA;
        default: ;
      endcase
    end
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      RDATA <= 8'h00;
    end else if (RD) begin
      unique case (ADDR)
        HWD_ADDR_DOG_CTRL:  RDATA <= ctrl_r;
        HWD_ADDR_MODE:      RDATA <= mode_reg_r;
        HWD_ADDR_WAKE_MASK: RDATA <= 8'(wake_mask_r);
        HWD_ADDR_STATUS:    RDATA <= {3'h0, low_osc_ok_r, HIGH_OSC_STABLE,
                                      dog_enabled, expiry_r, pdf_r};
        HWD_ADDR_CONFIG:    RDATA <= cfg_r;
        default:            RDATA <= 8'h00;
      endcase
    end else begin
      RDATA <= 8'h00;
    end
  end

  // ****************************************
  // Clear instructions
  // ****************************************
  // Disabled dog makes clear instructions no-ops
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      last_clr_two_r <= 1'b1;
    end else if (dog_enabled && CMD.clr_one) begin
      last_clr_two_r <= 1'b0;
    end else if (dog_enabled && CMD.clr_two) begin
      last_clr_two_r <= 1'b1;
    end
  end

  assign sw_clear = dog_enabled &&
                    (cfg_r[HWD_CFG_TWO_CLR_BIT]
                     ? ((CMD.clr_one && last_clr_two_r) || (CMD.clr_two && !last_clr_two_r))
                     : CMD.clr_single);

  // ****************************************
  // Halt entry and wake-up
  // ****************************************
  assign halt_go   = CMD.halt && (state_r == HWD_MODE_RUN);
  assign port_wake = |(port_a_r & ~PORT_A & wake_mask_r);
  assign irq_wake  = IRQ_REQ && !irq_pre_r;

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      port_a_r  <= '1;
      irq_pre_r <= 1'b0;
    end else begin
      port_a_r  <= PORT_A;
      // Flag pending at halt masks that source until it drops
      irq_pre_r <= halt_go ? IRQ_REQ : (irq_pre_r && IRQ_REQ);
    end
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      state_r <= HWD_MODE_RUN;
      RESUME  <= '0;
    end else begin
      RESUME <= '0;
      unique case (state_r)
        HWD_MODE_RUN: begin
          if (halt_go) begin
            if (!idle_bit) begin
              state_r <= HWD_MODE_STOP;
            end else if (keep_bit) begin
              state_r <= HWD_MODE_IDLE_FULL;
            end else begin
              state_r <= HWD_MODE_IDLE_SLOW;
            end
          end
        end
        default: begin
          // Reset wins, then dog, then port, then interrupt
          if (EXT_RESET) begin
            state_r           <= HWD_MODE_RUN;
            RESUME.full_reset <= 1'b1;
          end else if (dog_ovf) begin
            state_r          <= HWD_MODE_RUN;
            RESUME.dog_reset <= 1'b1;
          end else if (port_wake) begin
            state_r            <= HWD_MODE_RUN;
            RESUME.resume_next <= 1'b1;
          end else if (irq_wake) begin
            state_r <= HWD_MODE_RUN;
            if (IRQ_EN && !STACK_FULL) begin
              RESUME.take_irq <= 1'b1;
            end else begin
              RESUME.resume_next <= 1'b1;
            end
          end
        end
      endcase
    end
  end

  // ****************************************
  // Status flags
  // ****************************************
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      pdf_r    <= 1'b0;
      expiry_r <= 1'b0;
    end else begin
      if (halt_go) begin
        pdf_r <= 1'b1;
      end else if (sw_clear) begin
        pdf_r <= 1'b0;
      end
      // Time-out set wins over halt clear
      if (dog_ovf) begin
        expiry_r <= 1'b1;
      end else if (halt_go) begin
        expiry_r <= 1'b0;
      end
    end
  end

  // ****************************************
  // Watchdog source and counter
  // ****************************************
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      div_r <= 2'h0;
    end else if (CORE_CLK_EN) begin
      div_r <= div_r + 2'h1;
    end
  end

  // Core-sourced dog stalls whenever the core clock stops
  assign dog_tick = dog_enabled &&
                    (cfg_r[HWD_CFG_SRC_SUB_BIT] ? SUB_TICK
                     : (CORE_CLK_EN && div_r == 2'(HWD_CORE_DIV - 1)));
  assign dog_clear = halt_go || sw_clear || !dog_enabled;

  hwd_dog_counter #(
    .WIDTH (20)
  ) u_dog (
    .CLK      (CLK),
    .RESET_N  (RESET_N),
    .tick     (dog_tick),
    .clear    (dog_clear),
    .period   (ctrl_r[HWD_CTRL_PER_LSB +: 3]),
    .overflow (dog_ovf)
  );

  // ****************************************
  // Clock gating outputs
  // ****************************************
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      MODE        <= HWD_MODE_RUN;
      CORE_CLK_EN <= 1'b0;
      SUB_CLK_EN  <= 1'b1;
    end else begin
      MODE        <= state_r;
      CORE_CLK_EN <= (state_r == HWD_MODE_IDLE_FULL) || (state_r == HWD_MODE_RUN &&
                     (HIGH_OSC_STABLE || !HIGH_OSC_SRC || RUN_ON_SUB));
      SUB_CLK_EN  <= (state_r != HWD_MODE_STOP) || dog_enabled;
    end
  end

  // ****************************************
  // Shared start-up timer
  // ****************************************
  // High crystal first, then low crystal reuses the same counter
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      osc_r           <= HWD_OSC_HIGH;
      sst_r           <= '0;
      HIGH_OSC_STABLE <= 1'b0;
      low_osc_ok_r    <= 1'b0;
    end else if (halt_go && !idle_bit) begin
      osc_r           <= HWD_OSC_OFF;
      HIGH_OSC_STABLE <= !HIGH_OSC_SRC;
      low_osc_ok_r    <= dog_enabled && low_osc_ok_r;
    end else begin
      unique case (osc_r)
        HWD_OSC_OFF: begin
          if (state_r == HWD_MODE_RUN) begin
            osc_r <= HIGH_OSC_SRC ? HWD_OSC_HIGH : HWD_OSC_LOW;
            sst_r <= '0;
          end
        end
        HWD_OSC_HIGH: begin
          sst_r <= sst_r + 11'h001;
          if (sst_r == 11'(STARTUP_CNT - 1)) begin
            HIGH_OSC_STABLE <= 1'b1;
            sst_r           <= '0;
            osc_r           <= (low_osc_ok_r || !cfg_r[HWD_CFG_LXT_BIT])
                               ? HWD_OSC_DONE : HWD_OSC_LOW;
          end
        end
        HWD_OSC_LOW: begin
          sst_r <= sst_r + 11'h001;
          if (sst_r == 11'(STARTUP_CNT - 1)) begin
            low_osc_ok_r <= 1'b1;
            osc_r        <= HWD_OSC_DONE;
          end
        end
        HWD_OSC_DONE: ;
      endcase
    end
  end

  // With the dog enabled, fast wake runs on the sub clock until the high crystal settles
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      RUN_ON_SUB <= 1'b0;
    end else begin
      RUN_ON_SUB <= mode_reg_r[HWD_MODE_FAST_BIT] && HIGH_OSC_SRC &&
                    dog_enabled && !HIGH_OSC_STABLE;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  a_slow_idle_entry: assert property (@(posedge CLK) disable iff (!RESET_N)
    halt_go && idle_bit && !keep_bit |=> state_r == HWD_MODE_IDLE_SLOW)
    else $error("idle slow not entered");
  a_full_idle_entry: assert property (@(posedge CLK) disable iff (!RESET_N)
    halt_go && idle_bit && keep_bit |=> state_r == HWD_MODE_IDLE_FULL)
    else $error("idle full not entered");
  a_slow_core_off: assert property (@(posedge CLK) disable iff (!RESET_N)
    state_r == HWD_MODE_IDLE_SLOW |=> !CORE_CLK_EN && SUB_CLK_EN)
    else $error("idle slow clock gating wrong");
  a_full_clocks_on: assert property (@(posedge CLK) disable iff (!RESET_N)
    state_r == HWD_MODE_IDLE_FULL |=> CORE_CLK_EN && SUB_CLK_EN)
    else $error("idle full clock gating wrong");
  a_halt_flags: assert property (@(posedge CLK) disable iff (!RESET_N)
    halt_go && !dog_ovf |=> pdf_r && !expiry_r)
    else $error("halt flags wrong");
  a_expiry_set: assert property (@(posedge CLK) disable iff (!RESET_N)
    dog_ovf |=> expiry_r)
    else $error("expiry flag not set");
  a_dog_wake_reset: assert property (@(posedge CLK) disable iff (!RESET_N)
    state_r != HWD_MODE_RUN && !EXT_RESET && dog_ovf
      |=> RESUME.dog_reset && state_r == HWD_MODE_RUN)
    else $error("dog wake missing");
  a_key_disable: assert property (@(posedge CLK) disable iff (!RESET_N)
    !cfg_r[HWD_CFG_DOG_EN_BIT] && ctrl_r[3:0] == HWD_KEY_DISABLE |-> !dog_tick)
    else $error("disabled dog ticked");
  a_pending_irq: assert property (@(posedge CLK) disable iff (!RESET_N)
    halt_go && IRQ_REQ ##1 (IRQ_REQ && !EXT_RESET && !dog_ovf && !port_wake)
      |=> !RESUME.take_irq && !RESUME.resume_next)
    else $error("pending irq woke device");
  a_core_waits_osc: assert property (@(posedge CLK) disable iff (!RESET_N)
    state_r == HWD_MODE_RUN && HIGH_OSC_SRC && !HIGH_OSC_STABLE && !RUN_ON_SUB |=> !CORE_CLK_EN)
    else $error("core ran before crystal stable");

endmodule : hwd_halt_wake

// ### pkg/hwd_pkg.sv
/*
 * Package for the halt, wake-up and watchdog block: register map, field
 * layout, reset values, mode and state types, and the carriers used
 * between the CPU core and the block.
 * Assumes a single 100 MHz clock domain and one register bus.
 */
package hwd_pkg;

  // ****************************************
  // Register map (word index equals address)
  // ****************************************
  localparam logic [3:0] HWD_ADDR_DOG_CTRL   = 4'h0;
  localparam logic [3:0] HWD_ADDR_MODE       = 4'h1;
  localparam logic [3:0] HWD_ADDR_WAKE_MASK  = 4'h2;
  localparam logic [3:0] HWD_ADDR_STATUS     = 4'h3;
  localparam logic [3:0] HWD_ADDR_CONFIG     = 4'h4;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int HWD_CTRL_KEEP_BIT   = 7;
  localparam int HWD_CTRL_PER_LSB    = 4;
  localparam int HWD_CTRL_KEY_LSB    = 0;
  localparam int HWD_MODE_IDLE_BIT   = 0;
  localparam int HWD_MODE_FAST_BIT   = 1;
  localparam int HWD_CFG_DOG_EN_BIT  = 0;
  localparam int HWD_CFG_SRC_SUB_BIT = 1;
  localparam int HWD_CFG_TWO_CLR_BIT = 2;
  localparam int HWD_CFG_LXT_BIT     = 3;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [7:0] HWD_CTRL_RESET   = 8'h7A;
  localparam logic [7:0] HWD_MODE_RESET   = 8'h00;
  localparam logic [7:0] HWD_WAKE_RESET   = 8'h00;
  localparam logic [7:0] HWD_CONFIG_RESET = 8'h03;
  localparam logic [3:0] HWD_KEY_DISABLE  = 4'hA;

  // ****************************************
  // Counts
  // ****************************************
  localparam int HWD_PER_BASE       = 13;
  localparam int HWD_CORE_DIV       = 4;
  localparam int HWD_STARTUP_CYCLES = 1024;

  typedef enum logic [1:0] {
    HWD_MODE_RUN,
    HWD_MODE_IDLE_SLOW,
    HWD_MODE_IDLE_FULL,
    HWD_MODE_STOP
  } hwd_mode_t;

  typedef enum logic [1:0] {
    HWD_OSC_OFF,
    HWD_OSC_HIGH,
    HWD_OSC_LOW,
    HWD_OSC_DONE
  } hwd_osc_t;

  // Instruction strobes from the core
  typedef struct packed {
    logic halt;
    logic clr_single;
    logic clr_one;
    logic clr_two;
  } hwd_cmd_t;

  // Wake-up resume directions to the core
  typedef struct packed {
    logic resume_next;
    logic take_irq;
    logic dog_reset;
    logic full_reset;
  } hwd_resume_t;

endpackage : hwd_pkg

// ### verilog/hwd_dog_counter.sv
/*
 * Watchdog counter: counts source ticks, flags overflow at 2^(13+code).
 * Assumes tick is a one-cycle pulse in the CLK domain.
 */
`timescale 1ns/100ps
module hwd_dog_counter #(
  parameter int WIDTH = 20
) (
  input  wire logic       CLK,
  input  wire logic       RESET_N,
  input  wire logic       tick,
  input  wire logic       clear,
  input  wire logic [2:0] period,
  output logic            overflow
);
  import hwd_pkg::*;

  logic [WIDTH:0] count_r;
  logic [WIDTH:0] limit;

  // Shift amount needs five bits: base plus code reaches 20
  assign limit = (WIDTH+1)'(1) << (5'(period) + 5'(HWD_PER_BASE));

  // Clear has priority; restart from zero after overflow
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      count_r <= '0;
    end else if (clear || overflow) begin
      count_r <= '0;
    end else if (tick) begin
      count_r <= count_r + (WIDTH+1)'(1);
    end
  end

  assign overflow = (count_r == limit);

endmodule : hwd_dog_counter

// ### verif/test_hwd_halt_wake.sv
/*
 * Self-checking bench for the halt, wake-up and watchdog controller.
 * Assumes hwd_pkg is compiled first; the bench drives every port itself.
 */
`timescale 1ns/100ps
module test_hwd_halt_wake;
  import hwd_pkg::*;

  localparam int LIMIT = 90000;

  logic        clk;
  logic        reset_n;
  logic [3:0]  addr;
  logic [7:0]  wdata;
  logic        wr;
  logic        rd;
  logic [7:0]  rdata;
  hwd_cmd_t    cmd;
  logic        ext_reset;
  logic [7:0]  port_a;
  logic        irq_req;
  logic        irq_en;
  logic        stack_full;
  logic        sub_tick;
  logic        high_osc_src;
  hwd_resume_t resume;
  hwd_mode_t   mode;
  logic        core_clk_en;
  logic        sub_clk_en;
  logic        run_on_sub;
  logic        high_osc_stable;
  int          n_mismatch;
  int          num_checks;
  int          cycles;
  int          cnt;

  // Short start-up count keeps the run brief
  hwd_halt_wake #(.PORT_W(8), .STARTUP_CNT(16)) uut (
    .CLK(clk), .RESET_N(reset_n), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
    .RDATA(rdata), .CMD(cmd), .EXT_RESET(ext_reset), .PORT_A(port_a),
    .IRQ_REQ(irq_req), .IRQ_EN(irq_en), .STACK_FULL(stack_full), .SUB_TICK(sub_tick),
    .HIGH_OSC_SRC(high_osc_src), .RESUME(resume), .MODE(mode),
    .CORE_CLK_EN(core_clk_en), .SUB_CLK_EN(sub_clk_en), .RUN_ON_SUB(run_on_sub),
    .HIGH_OSC_STABLE(high_osc_stable)
  );

  // ****************************************
  // Clock, timeout and shared tasks
  // ****************************************
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic complete_run();
    $display("Checks %0d, mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : complete_run

  always @(posedge clk) begin
    cycles = cycles + 1;
    if (cycles == LIMIT) begin
      n_mismatch = n_mismatch + 1;
      $display("[FAIL] %0t run hung", $time);
      complete_run();
    end
  end

  task automatic chk_val(input logic [7:0] got, input logic [7:0] exp, input string what);
    num_checks = num_checks + 1;
    if (got !== exp) begin
      n_mismatch = n_mismatch + 1;
      $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk_val

  task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask : reg_wr

  // Read data stand only in the cycle after the strobe
  task automatic reg_rd(input logic [3:0] a, input logic [7:0] mask, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1;
    chk_val(rdata & mask, exp, "register read");
  endtask : reg_rd

  task automatic send(input hwd_cmd_t c);
    @(posedge clk);
    cmd <= c;
    @(posedge clk);
    cmd <= '0;
  endtask : send

  task automatic halt_to(input hwd_mode_t m, input logic clk_on);
    send(hwd_cmd_t'(4'h8));
    @(posedge clk);
    #1;
    chk_val({6'h00, mode}, {6'h00, m}, "mode");
    chk_val({7'h00, core_clk_en}, {7'h00, clk_on}, "core clock enable");
    if (m != HWD_MODE_STOP) begin
      chk_val({7'h00, sub_clk_en}, 8'h01, "idle low-rate clock");
    end
  endtask : halt_to

  // Zero expected means no wake within the limit
  task automatic wait_wake(input int lim, input logic [3:0] exp);
    cnt = 0;
    while (resume === '0 && cnt < lim) begin
      @(posedge clk);
      #1;
      cnt = cnt + 1;
    end
    chk_val({4'h0, resume}, {4'h0, exp}, "resume");
    if (exp !== 4'h0) begin
      @(posedge clk);
      #1;
      chk_val({6'h00, mode}, {6'h00, HWD_MODE_RUN}, "mode after wake");
      chk_val({7'h00, core_clk_en}, 8'h01, "core clock after wake");
    end
  endtask : wait_wake

  // ****************************************
  // Test sequence
  // ****************************************
  initial begin
    n_mismatch = 0;
    num_checks = 0;
    cycles = 0;
    reset_n = 1'b0;
    addr = 4'h0;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
    cmd = '0;
    ext_reset = 1'b0;
    port_a = 8'hFF;
    irq_req = 1'b0;
    irq_en = 1'b0;
    stack_full = 1'b0;
    sub_tick = 1'b0;
    high_osc_src = 1'b1;
    repeat (12) @(posedge clk);
    reset_n <= 1'b1;
    repeat (20) @(posedge clk);
    reg_rd(HWD_ADDR_DOG_CTRL, 8'hFF, 8'h7A);
    reg_rd(HWD_ADDR_MODE, 8'hFF, 8'h00);
    reg_rd(HWD_ADDR_WAKE_MASK, 8'hFF, 8'h00);
    reg_rd(HWD_ADDR_CONFIG, 8'hFF, 8'h03);
    reg_wr(4'h5, 8'hFF);
    reg_rd(4'h5, 8'hFF, 8'h00);
    reg_wr(HWD_ADDR_STATUS, 8'hFF);
    reg_rd(HWD_ADDR_STATUS, 8'h0F, 8'h0C);
    chk_val({7'h00, high_osc_stable}, 8'h01, "oscillator stable");
    reg_wr(HWD_ADDR_DOG_CTRL, 8'hF5);
    reg_rd(HWD_ADDR_DOG_CTRL, 8'hFF, 8'hF5);
    // Option disable needs key 1010 as well
    reg_wr(HWD_ADDR_CONFIG, 8'h02);
    reg_rd(HWD_ADDR_STATUS, 8'h04, 8'h04);
    reg_wr(HWD_ADDR_DOG_CTRL, 8'h7A);
    reg_rd(HWD_ADDR_STATUS, 8'h04, 8'h00);
    reg_wr(HWD_ADDR_CONFIG, 8'h03);
    reg_rd(HWD_ADDR_STATUS, 8'h04, 8'h04);
    reg_wr(HWD_ADDR_WAKE_MASK, 8'h01);
    reg_wr(HWD_ADDR_MODE, 8'h01);
    reg_wr(HWD_ADDR_DOG_CTRL, 8'h05);
    halt_to(HWD_MODE_IDLE_SLOW, 1'b0);
    reg_rd(HWD_ADDR_STATUS, 8'h03, 8'h01);
    @(posedge clk);
    port_a <= 8'hFD;
    wait_wake(10, 4'h0);
    @(posedge clk);
    port_a <= 8'hFC;
    wait_wake(10, 4'h8);
    port_a <= 8'hFF;
    reg_wr(HWD_ADDR_DOG_CTRL, 8'h85);
    for (int i = 0; i < 3; i++) begin
      irq_en <= (i != 1);
      stack_full <= (i == 2);
      halt_to(HWD_MODE_IDLE_FULL, 1'b1);
      @(posedge clk);
      irq_req <= 1'b1;
      wait_wake(10, (i == 0) ? 4'h4 : 4'h8);
      irq_req <= 1'b0;
    end
    send(hwd_cmd_t'(4'h4));
    reg_rd(HWD_ADDR_STATUS, 8'h03, 8'h00);
    // Low-rate ticks every cycle: period code 0 expires after 8192
    @(posedge clk);
    sub_tick <= 1'b1;
    reg_wr(HWD_ADDR_DOG_CTRL, 8'h05);
    halt_to(HWD_MODE_IDLE_SLOW, 1'b0);
    wait_wake(9000, 4'h2);
    chk_val({7'h00, cnt >= 8185 && cnt <= 8200}, 8'h01, "low-rate period");
    reg_rd(HWD_ADDR_STATUS, 8'h03, 8'h03);
    // Core clock divided by four keeps counting in full-clock idle
    reg_wr(HWD_ADDR_CONFIG, 8'h01);
    reg_wr(HWD_ADDR_DOG_CTRL, 8'h85);
    halt_to(HWD_MODE_IDLE_FULL, 1'b1);
    reg_rd(HWD_ADDR_STATUS, 8'h03, 8'h01);
    wait_wake(34000, 4'h2);
    chk_val({7'h00, cnt >= 32755 && cnt <= 32790}, 8'h01, "core period");
    reg_wr(HWD_ADDR_DOG_CTRL, 8'h05);
    halt_to(HWD_MODE_IDLE_SLOW, 1'b0);
    wait_wake(34000, 4'h0);
    @(posedge clk);
    port_a <= 8'hFE;
    wait_wake(10, 4'h8);
    port_a <= 8'hFF;
    // Request already set at halt must not wake
    irq_en <= 1'b0;
    irq_req <= 1'b1;
    halt_to(HWD_MODE_IDLE_SLOW, 1'b0);
    wait_wake(20, 4'h0);
    @(posedge clk);
    ext_reset <= 1'b1;
    wait_wake(10, 4'h1);
    ext_reset <= 1'b0;
    irq_req <= 1'b0;
    // Deep stop, dog off: high then low crystal restart on one timer
    reg_wr(HWD_ADDR_CONFIG, 8'h0A);
    reg_wr(HWD_ADDR_DOG_CTRL, 8'h0A);
    reg_wr(HWD_ADDR_MODE, 8'h00);
    halt_to(HWD_MODE_STOP, 1'b0);
    chk_val({6'h00, sub_clk_en, high_osc_stable}, 8'h00, "deep stop clocks");
    @(posedge clk);
    port_a <= 8'hFE;
    @(posedge clk);
    #1;
    chk_val({4'h0, resume}, 8'h08, "deep stop wake");
    @(posedge clk);
    #1;
    chk_val({6'h00, core_clk_en, high_osc_stable}, 8'h00, "core held for crystal");
    port_a <= 8'hFF;
    repeat (20) @(posedge clk);
    #1;
    chk_val({6'h00, core_clk_en, high_osc_stable}, 8'h03, "core after crystal");
    reg_rd(HWD_ADDR_STATUS, 8'h18, 8'h08);
    repeat (20) @(posedge clk);
    reg_rd(HWD_ADDR_STATUS, 8'h18, 8'h18);
    // Stop with dog running: fast wake starts on the low-rate clock
    reg_wr(HWD_ADDR_CONFIG, 8'h07);
    reg_wr(HWD_ADDR_DOG_CTRL, 8'h05);
    reg_wr(HWD_ADDR_MODE, 8'h02);
    halt_to(HWD_MODE_STOP, 1'b0);
    chk_val({6'h00, sub_clk_en, run_on_sub}, 8'h03, "stop with dog clocks");
    @(posedge clk);
    port_a <= 8'hFE;
    @(posedge clk);
    #1;
    chk_val({4'h0, resume}, 8'h08, "fast wake");
    @(posedge clk);
    #1;
    chk_val({6'h00, core_clk_en, run_on_sub}, 8'h03, "core on low-rate clock");
    port_a <= 8'hFF;
    repeat (20) @(posedge clk);
    #1;
    chk_val({6'h00, core_clk_en, run_on_sub}, 8'h02, "back on crystal");
    // Two-clear option: a first clr_two is refused, clr_one then clears
    send(hwd_cmd_t'(4'h1));
    reg_rd(HWD_ADDR_STATUS, 8'h01, 8'h01);
    send(hwd_cmd_t'(4'h2));
    reg_rd(HWD_ADDR_STATUS, 8'h01, 8'h00);
    complete_run();
  end

endmodule : test_hwd_halt_wake
